// ==== src/restart_pkg.sv ====
// Shared timing constants and state enumeration for the control unit.
package restart_pkg;
	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_MHZ          = 200;
	localparam int BLANK_TIME_MS    = 20;
	localparam int SPIKE_TIME_US    = 30;
	localparam int OVP_QUAL_TIME_US = 120;
	localparam int START_MASK_MS    = 1;
	localparam int TICK_TIME_US     = 1;
	localparam int TICK_CYCLES      = TICK_TIME_US * CLK_MHZ;
	localparam int BLANK_TICKS      = BLANK_TIME_MS * 1000 / TICK_TIME_US;
	localparam int SPIKE_TICKS      = SPIKE_TIME_US / TICK_TIME_US;
	localparam int OVP_QUAL_TICKS   = OVP_QUAL_TIME_US / TICK_TIME_US;
	localparam int START_MASK_TICKS = START_MASK_MS * 1000 / TICK_TIME_US;
	localparam int SOFT_START_TICKS = 10000;
	localparam int CNT_W            = 16;
	localparam int TICK_W           = 8;

	// ****************************************************************
	// Operating states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_BURST,
		ST_RESTART,
		ST_CHARGE,
		ST_SOFT
	} mode_e;
endpackage : restart_pkg

// ==== src/flag_sync.sv ====
// Two-stage synchroniser bank for the comparator flags.
module flag_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// ****************************************************************
	// Synchroniser
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : flag_sync

// ==== src/burst_and_fault_restart_control.sv ====
// Burst sequencing and auto-restart protection for the supply controller.
// Summary of operation
// - Low-load flag starts blanking count; burst only if held full interval.
// - Entering burst sets burst flag and switches bias off.
// - In burst, upper threshold re-enables bias and switching.
// - Burst selects reduced current limit.
// - In burst, lower threshold switches bias off until upper crossed.
// - Lower-threshold shutdown stays enabled while burst flag set.
// - High feedback in burst leaves burst, restores full limit.
// - Overvoltage, heat, undervoltage, opto short, external go straight.
// - Basic plus extended blanking only for overload and open loop.
// - Restart stops switching; startup cell charges supply; then soft start.
// - After soft start recheck fault; restart again or resume normal.
// - Overload starts blanking count; at basic time release clamp.
// - Overload and pin-high held a spike interval enters restart.
// - Pin charge from clamp to upper level is extended blanking.
// - In soft start, overvoltage with high feedback enters restart.
// - High overvoltage held qualification time enters restart from normal or soft start.
// - High overvoltage ignored during burst.
// - Thermal flag enters restart immediately.
// - Pin pulled low stops switching now; restart follows on the next clock.
// - External restart masked during start-up delay window.
// - Supply below turn-off threshold: off, startup cell on, restart.
module burst_and_fault_restart_control
	import restart_pkg::*;
#(
	parameter int BLANK_CNT = restart_pkg::BLANK_TICKS,
	parameter int MASK_CNT  = restart_pkg::START_MASK_TICKS,
	parameter int SOFT_CNT  = restart_pkg::SOFT_START_TICKS
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic high_feedback_comparator,
	input  wire logic low_load_comparator,
	input  wire logic burst_upper_comparator,
	input  wire logic burst_lower_comparator,
	input  wire logic supply_overvoltage_comparator,
	input  wire logic supply_high_ovp_comparator,
	input  wire logic over_temp_comparator,
	input  wire logic supply_on_comparator,
	input  wire logic supply_off_comparator,
	input  wire logic blank_pin_upper_comparator,
	input  wire logic external_restart_comparator,
	output logic      bias_enable,
	output logic      switch_enable,
	output logic      burst_flag,
	output logic      reduced_limit_gate,
	output logic      blanking_clamp_switch,
	output logic      startup_cell_enable,
	output logic      restart_active,
	output logic      soft_start
);
	import restart_pkg::*;

	localparam int NFLAGS = 11;

	logic [NFLAGS-1:0] raw_flags;
	logic [NFLAGS-1:0] flags;
	logic              hi_fb;
	logic              low_ld;
	logic              up_b;
	logic              lo_b;
	logic              ovp;
	logic              ovp_hi;
	logic              hot;
	logic              vcc_on;
	logic              vcc_off;
	logic              ba_up;
	logic              ext_rq;
	logic              tick;
	logic [TICK_W-1:0] tick_cnt;
	mode_e             mode;
	mode_e             next_mode;
	logic [CNT_W-1:0]  low_cnt;
	logic [CNT_W-1:0]  ovl_cnt;
	logic [CNT_W-1:0]  spike_cnt;
	logic [CNT_W-1:0]  ovp_cnt;
	logic [CNT_W-1:0]  mask_cnt;
	logic [CNT_W-1:0]  soft_cnt;
	logic              mask_done;
	logic              bias_on;
	logic              fast_fault;
	logic              slow_fault;
	logic              burst_enter;
	logic              fault;

	// ****************************************************************
	// Flag synchronisation
	// ****************************************************************
	assign raw_flags = {external_restart_comparator,
		blank_pin_upper_comparator, supply_off_comparator,
		supply_on_comparator, over_temp_comparator,
		supply_high_ovp_comparator, supply_overvoltage_comparator,
		burst_lower_comparator, burst_upper_comparator,
		low_load_comparator, high_feedback_comparator};

	flag_sync #(
		.WIDTH(NFLAGS)
	) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.async_in(raw_flags),
		.sync_out(flags)
	);

	assign {ext_rq, ba_up, vcc_off, vcc_on, hot, ovp_hi, ovp,
		lo_b, up_b, low_ld, hi_fb} = flags;

	// ****************************************************************
	// Timebase
	// ****************************************************************
	// A single microsecond tick keeps every counter narrow.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			tick     <= 1'b0;
		end
	end

	function automatic logic [CNT_W-1:0] count_up(
		input logic             run,
		input logic [CNT_W-1:0] cnt,
		input int               limit
	);
		if (!run)
			count_up = '0;
		else if (tick && cnt < CNT_W'(limit))
			count_up = cnt + 1'b1;
		else
			count_up = cnt;
	endfunction : count_up

	// ****************************************************************
	// Blanking and filter counters
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			low_cnt <= '0;
		end else begin
			low_cnt <= count_up(mode == ST_NORMAL && low_ld, low_cnt,
				BLANK_CNT);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovl_cnt <= '0;
		end else begin
			ovl_cnt <= count_up(mode == ST_NORMAL && hi_fb, ovl_cnt,
				BLANK_CNT);
		end
	end

	// The clamp holds the pin low until the basic interval ends; the
	// external capacitor then sets the extra delay on its own.
	assign blanking_clamp_switch =
		!(ovl_cnt == CNT_W'(BLANK_CNT));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			spike_cnt <= '0;
		end else begin
			spike_cnt <= count_up(mode == ST_NORMAL && hi_fb && ba_up &&
				!blanking_clamp_switch, spike_cnt, SPIKE_TICKS);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovp_cnt <= '0;
		end else begin
			ovp_cnt <= count_up(ovp_hi && mode != ST_BURST, ovp_cnt,
				OVP_QUAL_TICKS);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_cnt <= '0;
		end else begin
			mask_cnt <= count_up(1'b1, mask_cnt, MASK_CNT);
		end
	end

	assign mask_done = mask_cnt == CNT_W'(MASK_CNT);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			soft_cnt <= '0;
		end else begin
			soft_cnt <= count_up(mode == ST_SOFT, soft_cnt, SOFT_CNT);
		end
	end

	// ****************************************************************
	// Fault qualification
	// ****************************************************************
	assign fast_fault = hot
		|| vcc_off
		|| (ext_rq && mask_done)
		|| ovp_cnt == CNT_W'(OVP_QUAL_TICKS);
	assign slow_fault = spike_cnt == CNT_W'(SPIKE_TICKS);
	assign burst_enter = low_ld && low_cnt == CNT_W'(BLANK_CNT);
	assign fault = fast_fault || slow_fault;

	// ****************************************************************
	// Mode sequencing
	// ****************************************************************
	always_comb begin
		next_mode = mode;
		case (mode)
			ST_NORMAL: begin
				if (fault)
					next_mode = ST_RESTART;
				else if (burst_enter)
					next_mode = ST_BURST;
			end
			ST_BURST: begin
				if (fault)
					next_mode = ST_RESTART;
				else if (hi_fb)
					next_mode = ST_NORMAL;
			end
			ST_RESTART: begin
				if (vcc_off)
					next_mode = ST_CHARGE;
			end
			ST_CHARGE: begin
				if (vcc_on)
					next_mode = ST_SOFT;
			end
			ST_SOFT: begin
				if (fast_fault || (ovp && hi_fb))
					next_mode = ST_RESTART;
				else if (soft_cnt == CNT_W'(SOFT_CNT))
					next_mode = hi_fb ? ST_RESTART : ST_NORMAL;
			end
			default: next_mode = ST_RESTART;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			mode <= ST_CHARGE;
		else
			mode <= next_mode;
	end

	// ****************************************************************
	// Burst bias toggling
	// ****************************************************************
	// Bias keeps its last state between the two burst thresholds so the feedback
	// saw-tooth sets the burst rate.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bias_on <= 1'b0;
		end else if (mode != ST_BURST) begin
			bias_on <= 1'b0;
		end else if (up_b) begin
			bias_on <= 1'b1;
		end else if (lo_b && burst_flag) begin
			bias_on <= 1'b0;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			burst_flag          <= 1'b0;
			reduced_limit_gate  <= 1'b0;
			restart_active      <= 1'b0;
			startup_cell_enable <= 1'b1;
			soft_start          <= 1'b0;
			bias_enable         <= 1'b0;
		end else begin
			burst_flag          <= next_mode == ST_BURST;
			reduced_limit_gate  <= next_mode == ST_BURST;
			restart_active      <= next_mode == ST_RESTART ||
				next_mode == ST_CHARGE;
			startup_cell_enable <= next_mode == ST_CHARGE;
			soft_start          <= next_mode == ST_SOFT;
			bias_enable         <= next_mode == ST_NORMAL ||
				next_mode == ST_SOFT ||
				(next_mode == ST_BURST && bias_on);
		end
	end

	// The external request cuts the gate at once, ahead of the mode change.
	assign switch_enable = bias_enable && !(ext_rq && mask_done) &&
		!restart_active;
endmodule : burst_and_fault_restart_control

// ==== test/restart_checker_props.sv ====
// Port-level assertions for burst and restart sequencing.
module restart_checker #(
	parameter int BLANK_CNT = 20,
	parameter int MASK_CNT  = 1000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic high_feedback_comparator,
	input wire logic low_load_comparator,
	input wire logic burst_upper_comparator,
	input wire logic burst_lower_comparator,
	input wire logic over_temp_comparator,
	input wire logic external_restart_comparator,
	input wire logic bias_enable,
	input wire logic switch_enable,
	input wire logic burst_flag,
	input wire logic blanking_clamp_switch,
	input wire logic startup_cell_enable,
	input wire logic restart_active,
	input wire logic soft_start
);
	// Raw flags are counted, so the bounds leave room for the sync stages.
	int lo_cnt;
	int hi_cnt;
	int up_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk) lo_cnt <= low_load_comparator ? lo_cnt + 1 : 0;
	always_ff @(posedge clk)
		hi_cnt <= high_feedback_comparator ? hi_cnt + 1 : 0;
	// Cycles since reset release; the margin covers the start-up mask.
	always_ff @(posedge clk)
		up_cnt <= !rst_n ? 0 : (up_cnt < 100000 ? up_cnt + 1 : up_cnt);
	a_switch_gate: assert property (
		(external_restart_comparator && up_cnt > (MASK_CNT + 1) * 200)[*2]
		|=> !switch_enable)
		else $error("switching during external restart request");
	a_thermal_restart: assert property (
		over_temp_comparator |-> ##[1:4] restart_active)
		else $error("no restart on overtemperature");
	a_burst_entry: assert property (
		$rose(burst_flag) |-> lo_cnt >= (BLANK_CNT - 1) * 200)
		else $error("burst entered too early");
	a_burst_bias: assert property (
		$rose(burst_flag) |-> !bias_enable && !switch_enable)
		else $error("bias on at burst entry");
	a_burst_upper: assert property (
		(burst_flag && burst_upper_comparator
		&& !high_feedback_comparator)[*5] |-> bias_enable)
		else $error("bias not resumed");
	a_burst_lower: assert property (
		(burst_flag && burst_lower_comparator)[*5] |-> !bias_enable)
		else $error("bias not cut");
	a_burst_exit: assert property (
		burst_flag && high_feedback_comparator |-> ##[1:4] !burst_flag)
		else $error("burst not left");
	a_clamp_open: assert property (
		$fell(blanking_clamp_switch) |-> hi_cnt >= (BLANK_CNT - 1) * 200)
		else $error("clamp opened too early");
	a_soft_entry: assert property (
		$rose(soft_start) |-> $past(startup_cell_enable))
		else $error("soft start without charge phase");
	c_burst: cover property ($rose(burst_flag));
	c_clamp: cover property ($fell(blanking_clamp_switch));
	c_soft: cover property ($rose(soft_start));
endmodule : restart_checker

bind burst_and_fault_restart_control restart_checker #(
	.BLANK_CNT(BLANK_CNT),
	.MASK_CNT (MASK_CNT)) restart_checker_inst (.*);

// ==== test/supply_partner.sv ====
// Behavioural comparators and blanking pin facing the control unit.
module supply_partner (
	input  wire logic        clk,
	input  wire logic [15:0] fb_mv,
	input  wire logic [15:0] vcc_mv,
	input  wire logic        hot,
	input  wire logic        ext,
	input  wire logic        blanking_clamp_switch,
	output logic             high_feedback_comparator,
	output logic             low_load_comparator,
	output logic             burst_upper_comparator,
	output logic             burst_lower_comparator,
	output logic             supply_overvoltage_comparator,
	output logic             supply_high_ovp_comparator,
	output logic             over_temp_comparator,
	output logic             supply_on_comparator,
	output logic             supply_off_comparator,
	output logic             blank_pin_upper_comparator,
	output logic             external_restart_comparator
);
	// A 1 mV per cycle ramp stands in for the extension capacitor.
	int ba_mv;
	always @(posedge clk)
		ba_mv <= blanking_clamp_switch ? 900 :
			ba_mv + 32'(ba_mv < 4000);
	assign high_feedback_comparator = fb_mv > 4000;
	assign low_load_comparator = fb_mv < 1350;
	assign burst_upper_comparator = fb_mv > 3500;
	assign burst_lower_comparator = fb_mv <= 3050;
	assign supply_overvoltage_comparator = vcc_mv > 20500;
	assign supply_high_ovp_comparator = vcc_mv > 25500;
	assign over_temp_comparator = hot;
	assign supply_on_comparator = vcc_mv >= 18000;
	assign supply_off_comparator = vcc_mv < 10500;
	assign external_restart_comparator = ext;
	assign blank_pin_upper_comparator = !ext && ba_mv >= 4000;
endmodule : supply_partner

// ==== test/tb_burst_and_fault_restart_control.sv ====
// Self-checking bench for burst and fault restart sequencing.
module tb_burst_and_fault_restart_control;
	timeunit 1ns;
	timeprecision 1ps;
	import restart_pkg::*;
	localparam int B = 20;
	localparam int M = 5;
	localparam int S = 10;
	localparam int T = 200;
	logic        clk, rst_n, hot, ext;
	logic [15:0] fb_mv, vcc_mv;
	logic        high_feedback_comparator, low_load_comparator;
	logic        burst_upper_comparator, burst_lower_comparator;
	logic        supply_overvoltage_comparator, supply_high_ovp_comparator;
	logic        over_temp_comparator, supply_on_comparator;
	logic        supply_off_comparator, blank_pin_upper_comparator;
	logic        external_restart_comparator, bias_enable, switch_enable;
	logic        burst_flag, reduced_limit_gate, blanking_clamp_switch;
	logic        startup_cell_enable, restart_active, soft_start;
	logic [7:0]  o;
	logic [7:0]  q[$];
	int          n_mismatch = 0;
	int          check_count = 0;
	int          seed = 54;
	event        got;
	assign o = {bias_enable, switch_enable, burst_flag, reduced_limit_gate,
		blanking_clamp_switch, startup_cell_enable, restart_active, soft_start};
	burst_and_fault_restart_control #(
		.BLANK_CNT(B), .MASK_CNT(M), .SOFT_CNT(S)
	) burst_and_fault_restart_control_inst (.*);
	supply_partner supply_partner_inst (.*);
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	always @(got) chk("outputs", o, q.pop_front());
	// Waits are bounded, so a stuck output shows as a late change.
	task automatic step(logic [15:0] f, v, logic [7:0] e, int lo, hi);
		int n;
		@(posedge clk) #1;
		fb_mv = f;
		vcc_mv = v;
		for (n = 0; o !== e && n < hi; n++) @(posedge clk) #1;
		q.push_back(e);
		->got;
		chk("delay", 8'(n >= lo && n < hi), 8'h01);
	endtask : step
	task automatic recover();
		step(2500, 10000, 8'h0E, 0, 10);
		step(2500, 18000, 8'hC9, 0, 10);
		step(2500, 18000, 8'hC8, (S - 1) * T, (S + 1) * T);
	endtask : recover
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	initial begin
		#500000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		rst_n = 0;
		hot = 0;
		ext = 1;
		fb_mv = 2500;
		vcc_mv = 9000;
		repeat (20) @(posedge clk);
		#1 rst_n = 1;
		step(2500, 9000, 8'h0E, 0, 10);
		step(2500, 18000, 8'hC9, 0, 10);
		ext = 0;
		step(2500, 18000, 8'hC8, (S - 1) * T, (S + 1) * T);
		$display("done: start up");
		step(1000, 18000, 8'h38, (B - 1) * T, (B + 2) * T);
		repeat (2) begin
			step(16'(3510 + {$random(seed)} % 400), 18000, 8'hF8, 0, 10);
			step(3000, 18000, 8'h38, 0, 10);
		end
		step(3000, 26000, 8'h38, 0, 10);
		repeat (125 * T) @(posedge clk);
		step(3000, 18000, 8'h38, 0, 1);
		step(4100, 18000, 8'hC8, 0, 10);
		$display("done: burst");
		step(4100, 18000, 8'hC0, (B - 1) * T, (B + 2) * T);
		step(4100, 18000, 8'h0A, 3100 + 29 * T, 3100 + 32 * T);
		step(4100, 10000, 8'h0E, 0, 10);
		step(4100, 18000, 8'hC9, 0, 10);
		step(4100, 18000, 8'h0A, (S - 1) * T, (S + 1) * T);
		step(4100, 10000, 8'h0E, 0, 10);
		step(4100, 21000, 8'h0A, 0, 20);
		recover();
		$display("done: overload");
		hot = 1;
		step(2500, 18000, 8'h0A, 0, 6);
		hot = 0;
		recover();
		step(2500, 26000, 8'h0A, 119 * T, 122 * T);
		recover();
		$display("done: fast faults");
		ext = 1;
		step(2500, 18000, 8'h88, 0, 5);
		ext = 0;
		step(2500, 18000, 8'h0A, 0, 5);
		recover();
		$display("done: external");
		give_verdict();
	end
endmodule : tb_burst_and_fault_restart_control
